// ### src/wesr_top.sv
// Register access over AHB-Lite was decided locally.
`timescale 1ns/100ps
`include "wesr_cfg.svh"

// Overview of operation
// - A source whose wake status and wake enable are both 1 pulls the active-low wake output low.
// - With its enable at 0 a source still shows its status but never pulls the wake output.
// - Wake enable register 0E maps bits 0 to 7 to group-five pins 0 to 7 in order.
// - Wake enable register 0F holds printer, midi, serial, floppy, mouse, keyboard, watchdog, two-wire enables in bits 0 to 7.
// - Both wake enable registers clear only on the standby power-on reset, not on main, soft or hard reset.
// - SMI status register 10 follows its sources directly and writes do not clear it.
// - Register 10 shows printer in bit 1, midi 2, serial 3, floppy 4, watchdog 7, others reserved.
// - Register 10 resets to 0x02 and bit 1 is forced to 1 by every kind of reset.
// - The printer status reads 1 while the port is not activated and follows the acknowledge input once activated.
// - In register 11 a written 1 clears bits 2 to 4 while bits 0 and 1 clear only with their source.
// - Register 11 shows mouse, keyboard, two-wire, ring indicate, keyboard-port event in bits 0 to 4, rest reserved.
// - Clearing a latched status bit leaves the event at its source, which software clears separately.
// - Register 12 shows pins 20 to 22 in bits 0 to 2, pin 60 in bit 3, pins 24 to 27 in bits 4 to 7, reset 0x00.
// - Writing 1 to a bit of register 12 clears it and writing 0 leaves it.
module wesr_top (
  // Clock and standby power-on reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Wake sources, already status-level
  input wire logic [7:0] wake_status_grp5,
  input wire logic [7:0] wake_status_periph,
  // SMI sources from pins
  input wire logic printer_ack_in,
  input wire logic midi_uart_irq,
  input wire logic serial_port_irq,
  input wire logic floppy_irq,
  input wire logic watchdog_event,
  input wire logic mouse_irq,
  input wire logic keyboard_irq,
  input wire logic two_wire_ctrl_event,
  input wire logic ring_indicate_event,
  input wire logic kbc_port_bit_event,
  input wire logic [7:0] gpio_grp2_smi,
  // Outputs
  output logic wake_event_out_n,
  output logic irq
);

  wesr_pkg::wesr_phase_t phase_q;
  logic [7:0] idx_q;
  logic [7:0] wake_en5_q;
  logic [7:0] wake_en6_q;
  logic [7:0] sts1_q;
  logic [7:0] sts2_q;
  logic [7:0] sts3_q;
  logic [2:0] irq_sts_q;
  logic [2:0] irq_mask_q;
  logic pport_act_q;
  logic [7:0] wsync1_q;
  logic [7:0] wsync2_q;
  logic [7:0] psync1_q;
  logic [7:0] psync2_q;
  logic [17:0] sync1_q;
  logic [17:0] sync2_q;
  logic wake_hit_q;

  logic addr_ok;
  logic [7:0] widx;
  logic [7:0] wdat;
  logic wr_en;
  logic main_reset;
  logic [7:0] sts1_src;
  logic [7:0] sts2_set;
  logic [7:0] sts3_set;
  logic [7:0] sts2_clr;
  logic [7:0] sts3_clr;
  logic wake_any;
  logic [31:0] rd_mux;

  assign widx = idx_q;
  assign wdat = hwdata[7:0];
  assign wr_en = (phase_q == wesr_pkg::WESR_WRITE);
  assign addr_ok = (haddr[1:0] == 2'h0) && (haddr[31:10] == 22'h000000);

  // Synchronisers for asynchronous pin inputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wsync1_q <= 8'h00;
      wsync2_q <= 8'h00;
      psync1_q <= 8'h00;
      psync2_q <= 8'h00;
      sync1_q <= 18'h00000;
      sync2_q <= 18'h00000;
    end
    else
    begin
      wsync1_q <= wake_status_grp5;
      wsync2_q <= wsync1_q;
      psync1_q <= wake_status_periph;
      psync2_q <= psync1_q;
      sync1_q <= {gpio_grp2_smi, kbc_port_bit_event, ring_indicate_event,
                  two_wire_ctrl_event, keyboard_irq, mouse_irq,
                  watchdog_event, floppy_irq, serial_port_irq,
                  midi_uart_irq, printer_ack_in};
      sync2_q <= sync1_q;
    end
  end

  // AHB-Lite address phase capture; zero wait states
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_q <= wesr_pkg::WESR_IDLE;
      idx_q <= 8'h00;
    end
    else if (hready)
    begin
      idx_q <= haddr[9:2];
      if (hsel && htrans[1] && addr_ok && hwrite)
        phase_q <= wesr_pkg::WESR_WRITE;
      else if (hsel && htrans[1] && addr_ok)
        phase_q <= wesr_pkg::WESR_READ;
      else
        phase_q <= wesr_pkg::WESR_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Self-timed reset kinds, written by software
  assign main_reset = wr_en && (widx == `WESR_IDX_RESET) && (wdat[2:0] != 3'h0);

  // Wake enables survive all but the standby reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wake_en5_q <= `WESR_RST_WAKE_EN;
      wake_en6_q <= `WESR_RST_WAKE_EN;
    end
    else if (wr_en && widx == `WESR_IDX_WAKE_EN5)
      wake_en5_q <= wdat;
    else if (wr_en && widx == `WESR_IDX_WAKE_EN6)
      wake_en6_q <= wdat;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pport_act_q <= 1'b0;
    else if (main_reset)
      pport_act_q <= 1'b0;
    else if (wr_en && widx == `WESR_IDX_CTRL)
      pport_act_q <= wdat[`WESR_CTRL_PPORT_ACT];
  end

  // Wake output, held in a flop so the pin is glitch free
  assign wake_any = |({wsync2_q & wake_en5_q, psync2_q & wake_en6_q});

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wake_event_out_n <= 1'b1;
      wake_hit_q <= 1'b0;
    end
    else
    begin
      wake_event_out_n <= ~wake_any;
      wake_hit_q <= wake_any;
    end
  end

  // Register 10 is live source state
  always_comb
  begin
    sts1_src = 8'h00;
    sts1_src[`WESR_PPORT_BIT] = pport_act_q ? sync2_q[0] : 1'b1;
    sts1_src[2] = sync2_q[1];
    sts1_src[3] = sync2_q[2];
    sts1_src[4] = sync2_q[3];
    sts1_src[7] = sync2_q[4];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sts1_q <= `WESR_RST_SMI_STATUS_PERIPHERALS;
    else if (main_reset)
      sts1_q <= `WESR_RST_SMI_STATUS_PERIPHERALS;
    else
      sts1_q <= sts1_src & `WESR_STS1_USED;
  end

  // Register 11: bits 0-1 live, 2-4 latched until a written 1
  assign sts2_set = {3'h0, sync2_q[9:7], 2'h0};
  assign sts2_clr = (wr_en && widx == `WESR_IDX_SMI_STATUS_INPUT_DEVICES) ?
                    (wdat & `WESR_STS2_W1C) : 8'h00;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sts2_q <= 8'h00;
    else
    begin
      sts2_q[1:0] <= sync2_q[6:5];
      sts2_q[4:2] <= sts2_set[4:2] | (sts2_q[4:2] & ~sts2_clr[4:2]);
      sts2_q[7:5] <= 3'h0;
    end
  end

  // Register 12: pins latch, set wins over a same-cycle clear
  assign sts3_set = sync2_q[17:10];
  assign sts3_clr = (wr_en && widx == `WESR_IDX_SMI_STATUS_GROUP2_PINS) ? wdat : 8'h00;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sts3_q <= `WESR_RST_SMI_STATUS_GROUP2_PINS;
    else
      sts3_q <= sts3_set | (sts3_q & ~sts3_clr);
  end

  // Interrupt: sticky event bits, write one to clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_sts_q <= 3'h0;
      irq_mask_q <= 3'h0;
    end
    else
    begin
      irq_sts_q <= {|sts3_set, |sts2_set, wake_any & ~wake_hit_q} |
                   (irq_sts_q & ~((wr_en && widx == `WESR_IDX_IRQ_STS) ?
                   wdat[2:0] : 3'h0));
      if (wr_en && widx == `WESR_IDX_IRQ_MASK)
        irq_mask_q <= wdat[2:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_sts_q & irq_mask_q);
  end

  // Read mux; unmapped words read zero
  always_comb
  begin
    rd_mux = 32'h00000000;
    if (hsel && htrans[1] && addr_ok && !hwrite)
    begin
      if (haddr[9:2] == `WESR_IDX_WAKE_EN5)
        rd_mux = {24'h000000, wake_en5_q};
      else if (haddr[9:2] == `WESR_IDX_WAKE_EN6)
        rd_mux = {24'h000000, wake_en6_q};
      else if (haddr[9:2] == `WESR_IDX_SMI_STATUS_PERIPHERALS)
        rd_mux = {24'h000000, sts1_q};
      else if (haddr[9:2] == `WESR_IDX_SMI_STATUS_INPUT_DEVICES)
        rd_mux = {24'h000000, sts2_q};
      else if (haddr[9:2] == `WESR_IDX_SMI_STATUS_GROUP2_PINS)
        rd_mux = {24'h000000, sts3_q};
      else if (haddr[9:2] == `WESR_IDX_IRQ_STS)
        rd_mux = {29'h00000000, irq_sts_q};
      else if (haddr[9:2] == `WESR_IDX_IRQ_MASK)
        rd_mux = {29'h00000000, irq_mask_q};
      else if (haddr[9:2] == `WESR_IDX_CTRL)
        rd_mux = {31'h00000000, pport_act_q};
    end
  end

  // Read data registered at the address phase edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (hready)
      hrdata <= rd_mux;
  end

endmodule

// ### src/wesr_cfg.svh
`ifndef WESR_CFG_SVH
`define WESR_CFG_SVH

// Register indices, printed offsets are indices (word address = 4*index)
`define WESR_IDX_WAKE_EN5 8'h0E
`define WESR_IDX_WAKE_EN6 8'h0F
`define WESR_IDX_SMI_STATUS_PERIPHERALS 8'h10
`define WESR_IDX_SMI_STATUS_INPUT_DEVICES 8'h11
`define WESR_IDX_SMI_STATUS_GROUP2_PINS 8'h12
`define WESR_IDX_IRQ_STS 8'h20
`define WESR_IDX_IRQ_MASK 8'h21
`define WESR_IDX_CTRL 8'h22
`define WESR_IDX_RESET 8'h23

// Reset values
`define WESR_RST_WAKE_EN 8'h00
`define WESR_RST_SMI_STATUS_PERIPHERALS 8'h02
`define WESR_RST_SMI_STATUS_GROUP2_PINS 8'h00

// Field masks
`define WESR_STS1_USED 8'h9E
`define WESR_STS2_SRC 8'h03
`define WESR_STS2_W1C 8'h1C
`define WESR_PPORT_BIT 1

// Control and reset register bits
`define WESR_CTRL_PPORT_ACT 0
`define WESR_RESET_SOFT 0
`define WESR_RESET_HARD 1
`define WESR_RESET_MAIN_POR 2

// Interrupt status bits
`define WESR_IRQ_WAKE 0
`define WESR_IRQ_STS2 1
`define WESR_IRQ_STS3 2

`endif

// ### src/wesr_pkg.sv
package wesr_pkg;

  typedef enum logic [1:0] {
    WESR_IDLE,
    WESR_WRITE,
    WESR_READ
  } wesr_phase_t;

endpackage

// ### tb/wesr_top_assertions.sv
`timescale 1ns/100ps
module wesr_checker (
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Wake path
  input wire logic [7:0] wake_status_grp5,
  input wire logic [7:0] wake_status_periph,
  input wire logic wake_event_out_n
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd(int idx);
    hsel && htrans[1] && hready && !hwrite && haddr == 32'(4 * idx);
  endsequence
  a_ready_high: assert property (hreadyout)
    else $error("wait state seen");
  a_resp_okay: assert property (!hresp)
    else $error("error response seen");
  a_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_sts1_rsvd: assert property (
    rd(16) |=> (hrdata[7:0] & 8'h61) == 8'h00)
    else $error("status one reserved bit set");
  a_sts2_rsvd: assert property (
    rd(17) |=> hrdata[7:5] == 3'h0)
    else $error("status two reserved bit set");
  a_unmapped_zero: assert property (
    rd(48) |=> hrdata == 32'h0)
    else $error("unmapped word not zero");
  a_kind_reads_zero: assert property (rd(35) |=> hrdata == 32'h0)
    else $error("reset kind word not zero");
  // Quiet sources must leave the wake line released
  a_wake_quiet: assert property (
    ((wake_status_grp5 | wake_status_periph) == 8'h00) [*4]
    |=> wake_event_out_n)
    else $error("wake output low with no source");
endmodule

bind wesr_top wesr_checker u_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .wake_status_grp5, .wake_status_periph, .wake_event_out_n
);

// ### tb/wesr_top_tb.sv
`timescale 1ns/100ps
module wesr_top_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic pack = 1'b0, hreadyout, hresp, wake_n, irq, i0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
  logic [1:0] htrans = 2'h0;
  logic [7:0] grp5 = 8'h00, periph = 8'h00, gp = 8'h00, a, m;
  logic [3:0] s1 = 4'h0;
  logic [4:0] s2 = 5'h00;
  int n_fail = 0, checks = 0, cyc = 0;

  always #10 hclk = ~hclk;

  wesr_top DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .wake_status_grp5(grp5), .wake_status_periph(periph),
    .printer_ack_in(pack), .midi_uart_irq(s1[0]), .serial_port_irq(s1[1]),
    .floppy_irq(s1[2]), .watchdog_event(s1[3]), .mouse_irq(s2[0]),
    .keyboard_irq(s2[1]), .two_wire_ctrl_event(s2[2]),
    .ring_indicate_event(s2[3]), .kbc_port_bit_event(s2[4]),
    .gpio_grp2_smi(gp), .wake_event_out_n(wake_n), .irq(irq)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx,
    input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(v, {24'h0, e});
  endtask

  // Two sync stages plus the register edge, with margin
  task automatic settle;
    repeat (5) @(posedge hclk);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      summarize();
    end
  end

  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h0E, 8'h00);
    rd(8'h0F, 8'h00);
    rd(8'h10, 8'h02);
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h00);
    rd(8'h30, 8'h00);
    rd(8'h23, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 16; i++)
    begin
      a = (i < 8) ? 8'h0E : 8'h0F;
      m = 8'h01 << (i % 8);
      bus(1'b1, a, m);
      rd(a, m);
      {periph, grp5} <= 16'h0001 << i;
      settle();
      chk(wake_n, 1'b0);
      {periph, grp5} <= 16'h0001 << ((i + 1) % 16);
      settle();
      chk(wake_n, 1'b1);
    end
    {periph, grp5} <= 16'h0000;
    $display("wake gating done");
    for (int i = 0; i < 4; i++)
    begin
      s1 <= 4'h1 << i;
      settle();
      rd(8'h10, (i == 3) ? 8'h82 : 8'h02 | (8'h04 << i));
    end
    bus(1'b1, 8'h10, 8'hFF);
    rd(8'h10, 8'h82);
    s1 <= 4'h0;
    settle();
    rd(8'h10, 8'h02);
    bus(1'b1, 8'h22, 8'h01);
    pack <= 1'b1;
    settle();
    rd(8'h10, 8'h02);
    for (int k = 0; k < 3; k++)
    begin
      bus(1'b1, 8'h22, 8'h01);
      pack <= 1'b0;
      settle();
      rd(8'h10, 8'h00);
      bus(1'b1, 8'h23, 8'h01 << k);
      rd(8'h10, 8'h02);
      rd(8'h0F, 8'h80);
    end
    $display("status one done");
    for (int i = 0; i < 5; i++)
    begin
      s2 <= 5'h01 << i;
      settle();
      bus(1'b1, 8'h11, 8'hFF);
      rd(8'h11, 8'h01 << i);
      s2 <= 5'h00;
      settle();
      rd(8'h11, (i < 2) ? 8'h00 : 8'h01 << i);
      bus(1'b1, 8'h11, 8'hFF);
      rd(8'h11, 8'h00);
    end
    $display("status two done");
    s2 <= 5'h04;
    settle();
    s2 <= 5'h00;
    bus(1'b1, 8'h21, 8'h00);
    settle();
    i0 = irq;
    bus(1'b1, 8'h21, 8'h07);
    settle();
    chk(irq ^ i0, 1'b1);
    bus(1'b1, 8'h11, 8'h04);
    bus(1'b1, 8'h20, 8'h07);
    settle();
    chk(irq, 1'b0);
    $display("interrupt done");
    for (int i = 0; i < 8; i++)
    begin
      gp <= 8'h01 << i;
      settle();
      gp <= 8'h00;
      settle();
      rd(8'h12, 8'h01 << i);
      bus(1'b1, 8'h12, ~(8'h01 << i));
      rd(8'h12, 8'h01 << i);
      bus(1'b1, 8'h12, 8'h01 << i);
      rd(8'h12, 8'h00);
    end
    $display("status three done");
    summarize();
  end
endmodule
